/* File: design/fuh_regs.svh */
`ifndef FUH_REGS_SVH
`define FUH_REGS_SVH
`define FUH_MARKER 16'hA1EC
`define FUH_REVISION 8'h03
`define FUH_HDR_LEN 8'h40
`define FUH_OFS_REV 8'h02
`define FUH_OFS_CMD 8'h03
`define FUH_OFS_TGT 8'h04
`define FUH_OFS_STAT 8'h05
`define FUH_OFS_FLAGS 8'h06
`define FUH_OFS_LEN 8'h08
`define FUH_OFS_LOC 8'h0C
`define FUH_OFS_PCHK 8'h3A
`define FUH_OFS_HCHK 8'h3E
`define FUH_CRC16_POLY 16'h1021
`define FUH_CRC16_INIT 16'h0000
`define FUH_CRC32_POLY 32'h04C11DB7
`define FUH_CRC32_INIT 32'hFFFFFFFF
`define FUH_RES_OK 8'h00
`define FUH_RES_TOO_LONG 8'hFA
`define FUH_RES_HDR_BAD 8'hFB
`define FUH_RES_PAY_BAD 8'hFC
// register map of the host controller's software port
`define FUH_REG_CTRL 4'h0
`define FUH_REG_TARGET 4'h1
`define FUH_REG_LENGTH 4'h2
`define FUH_REG_LOCATION 4'h3
`define FUH_REG_PCHK 4'h4
`define FUH_REG_STATUS 4'h5
`define FUH_REG_MASK 4'h6
`define FUH_REG_RESULT 4'h7
`define FUH_REG_TXDATA 4'h8
`define FUH_REG_INFO 4'h9
`endif

/* File: design/fuh_pkg.sv */
package fuh_pkg;
    typedef enum logic [2:0] {
        FUH_IDLE, FUH_HDR, FUH_PAY, FUH_RSP, FUH_DONE
    } fuh_state_e;
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } fuh_byte_s;
    typedef struct packed {
        fuh_state_e st;
        logic [7:0] idx;
        logic [31:0] left;
        logic [7:0] cmd;
        logic [7:0] tgt;
        logic [15:0] flags;
        logic [31:0] len;
        logic [31:0] loc;
        logic [31:0] pchk;
        logic [15:0] crc16;
        logic [15:0] rcrc;
        logic [7:0] pbyte;
        logic pfull;
        logic [7:0] rsp_cmd;
        logic [7:0] rsp_tgt;
        logic [7:0] result;
        logic rsp_hdr_ok;
        logic busy;
        logic [2:0] sts;
        logic [2:0] mask;
        fuh_byte_s tx;
        logic [31:0] rdata;
    } fuh_state_s;
endpackage : fuh_pkg

/* File: design/fuh_host.sv */
`timescale 1ns/1ns
`include "fuh_regs.svh"
module fuh_host (
    input wire logic clock, // 100 MHz system clock
    input wire logic rst_b, // asynchronous reset, active low
    input wire logic [3:0] addr, // register index
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    output logic irq, // level interrupt
    output fuh_pkg::fuh_byte_s tx, // frame byte to the device
    input wire logic tx_ready, // device takes tx byte
    input wire fuh_pkg::fuh_byte_s rx // response byte from device
);
    fuh_pkg::fuh_state_s s_reg;
    fuh_pkg::fuh_state_s s_next;

    // ---------------------------------------------------------
    // software view of the registers
    // ---------------------------------------------------------
    // 0 control: bit 0 starts a frame, bits 15:8 command code;
    //   reads back the command and the busy bit
    // 1 target selector, sent at header byte 4
    // 2 payload length in bytes, sent at header byte 8
    // 3 target location, sent at header byte 12
    // 4 payload check; software works out the crc-32 itself,
    //   which keeps a 32-bit crc engine out of this block
    // 5 status, write one to clear: bit 0 answer in,
    //   bit 1 answer malformed, bit 2 result not ok
    // 6 interrupt mask, same layout as status
    // 7 answer: selector, command, result, header ok
    // 8 payload byte in; reads back the buffer-full bit
    // 9 payload bytes still to send
    // 10 to 15 read as zero and ignore writes
    // writes to control are ignored while a frame is open,
    // so a second start cannot corrupt the frame in flight
    // the header crc-16 is built in hardware as the bytes
    // leave, so software never sees it; the answer check is
    // built the same way and compared at bytes 62 and 63

    // ---------------------------------------------------------
    // crc helpers, one byte per call, msb first
    // ---------------------------------------------------------
    // bit-serial form unrolled by the loop: eight xor-shift
    // steps per byte, short enough for one clock at 100 MHz
    function automatic logic [15:0] crc16_byte(input logic [15:0] c,
            input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ `FUH_CRC16_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc16_byte

    // header byte at index i, built from the latched order
    // reserved bytes and the status byte go out as zero;
    // flags stay zero since update frames always carry a check
    function automatic logic [7:0] hdr_byte(input fuh_pkg::fuh_state_s s,
            input logic [7:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            8'h00: b = 8'(`FUH_MARKER >> 8);
            8'h01: b = 8'(`FUH_MARKER);
            `FUH_OFS_REV: b = `FUH_REVISION;
            `FUH_OFS_CMD: b = s.cmd;
            `FUH_OFS_TGT: b = s.tgt;
            8'h06: b = s.flags[15:8];
            8'h07: b = s.flags[7:0];
            8'h08: b = s.len[31:24];
            8'h09: b = s.len[23:16];
            8'h0A: b = s.len[15:8];
            8'h0B: b = s.len[7:0];
            8'h0C: b = s.loc[31:24];
            8'h0D: b = s.loc[23:16];
            8'h0E: b = s.loc[15:8];
            8'h0F: b = s.loc[7:0];
            8'h3A: b = s.pchk[31:24];
            8'h3B: b = s.pchk[23:16];
            8'h3C: b = s.pchk[15:8];
            8'h3D: b = s.pchk[7:0];
            8'h3E: b = s.crc16[15:8];
            8'h3F: b = s.crc16[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction : hdr_byte

    // ---------------------------------------------------------
    // next state
    // ---------------------------------------------------------
    // a frame walks idle, header, payload, answer, idle:
    // header sends the 64 bytes built by hdr_byte, one per
    // accepted byte, and folds bytes 2 to 61 into the crc-16;
    // payload forwards each byte that software writes, one
    // buffer deep, so software must poll the full bit;
    // answer waits for the 64 answer bytes from the device.
    // zero-length frames skip the payload phase entirely.
    // the answer parser and the header sender share idx,
    // which is safe since the device answers only after
    // the last byte it was sent
    always_comb begin
        logic [7:0] b;
        logic [2:0] ev;
        logic rsp_end;
        b = 8'h00;
        ev = 3'b000;
        rsp_end = 1'b0;
        s_next = s_reg;
        s_next.rdata = 32'h0000_0000;
        case (s_reg.st)
            fuh_pkg::FUH_IDLE: begin
                // nothing to send; no stale byte may stand on the link
                s_next.tx.valid = 1'b0;
            end
            fuh_pkg::FUH_HDR: begin
                // a byte stands until the device takes it
                if (!s_reg.tx.valid || tx_ready) begin
                    b = hdr_byte(s_reg, s_reg.idx);
                    s_next.tx.data = b;
                    s_next.tx.valid = 1'b1;
                    if (s_reg.idx >= `FUH_OFS_REV &&
                            s_reg.idx < `FUH_OFS_HCHK) begin
                        s_next.crc16 = crc16_byte(s_reg.crc16, b);
                    end
                    s_next.idx = s_reg.idx + 8'h01;
                    if (s_reg.idx == `FUH_HDR_LEN - 8'h01) begin
                        // the answer parser reuses idx from zero
                        s_next.idx = 8'h00;
                        s_next.st = (s_reg.len == 32'h0)
                            ? fuh_pkg::FUH_RSP : fuh_pkg::FUH_PAY;
                    end
                end
            end
            fuh_pkg::FUH_PAY: begin
                if (tx_ready && s_reg.tx.valid) begin
                    s_next.tx.valid = 1'b0;
                end
                // software feeds payload through the data register
                if (s_reg.pfull && (!s_next.tx.valid)) begin
                    s_next.tx.data = s_reg.pbyte;
                    s_next.tx.valid = 1'b1;
                    s_next.pfull = 1'b0;
                    s_next.left = s_reg.left - 32'h1;
                    if (s_reg.left == 32'h1) begin
                        s_next.st = fuh_pkg::FUH_RSP;
                    end
                end
            end
            fuh_pkg::FUH_RSP: begin
                // let the last byte go, then only listen
                if (tx_ready && s_reg.tx.valid) begin
                    s_next.tx.valid = 1'b0;
                end
            end
            default: begin
                s_next.st = fuh_pkg::FUH_IDLE;
            end
        endcase

        // -----------------------------------------------------
        // answer parser
        // -----------------------------------------------------
        // bytes seen while the payload goes out are taken as the
        // start of an early answer: the parser restarts at one,
        // checking the first byte against the marker. the check
        // bits are built as the bytes pass, so no copy of the
        // answer header is kept
        // response parser, counts 64 header bytes from the device
        if (rx.valid && s_reg.busy && s_reg.st != fuh_pkg::FUH_HDR) begin
            s_next.idx = s_reg.idx + 8'h01;
            if (s_reg.st != fuh_pkg::FUH_RSP) begin
                s_next.idx = 8'h01;
            end
            case (s_reg.st == fuh_pkg::FUH_RSP ? s_reg.idx : 8'h00)
                8'h00: s_next.rsp_hdr_ok = (rx.data == 8'hA1);
                8'h01: s_next.rsp_hdr_ok = s_reg.rsp_hdr_ok
                    && (rx.data == 8'hEC);
                `FUH_OFS_REV: s_next.rsp_hdr_ok = s_reg.rsp_hdr_ok
                    && (rx.data == `FUH_REVISION);
                `FUH_OFS_CMD: s_next.rsp_cmd = rx.data;
                `FUH_OFS_TGT: s_next.rsp_tgt = rx.data;
                `FUH_OFS_STAT: s_next.result = rx.data;
                8'h3E: s_next.rsp_hdr_ok = s_reg.rsp_hdr_ok
                    && (rx.data == s_reg.rcrc[15:8]);
                8'h3F: begin
                    s_next.rsp_hdr_ok = s_reg.rsp_hdr_ok
                        && (rx.data == s_reg.rcrc[7:0]);
                    rsp_end = 1'b1;
                end
                default: ;
            endcase
            // answer check over bytes 2 to 61, as for the header
            if (s_reg.st == fuh_pkg::FUH_RSP && s_reg.idx >= `FUH_OFS_REV
                    && s_reg.idx < `FUH_OFS_HCHK) begin
                s_next.rcrc = crc16_byte(s_reg.rcrc, rx.data);
            end
        end
        // end of answer: raise the events; a mismatched
        // command echo counts as a malformed answer
        if (rsp_end) begin
            s_next.st = fuh_pkg::FUH_IDLE;
            s_next.busy = 1'b0;
            ev[0] = 1'b1;
            ev[1] = !s_next.rsp_hdr_ok || s_reg.rsp_cmd != s_reg.cmd;
            ev[2] = s_next.result != `FUH_RES_OK;
        end

        // -----------------------------------------------------
        // register writes
        // -----------------------------------------------------
        // register port
        if (wr) begin
            case (addr)
                `FUH_REG_CTRL: begin
                    if (wdata[0] && !s_reg.busy) begin
                        s_next.st = fuh_pkg::FUH_HDR;
                        s_next.busy = 1'b1;
                        s_next.idx = 8'h00;
                        s_next.cmd = wdata[15:8];
                        // flags stay clear: update frames must be checked
                        s_next.flags = 16'h0000;
                        s_next.left = s_reg.len;
                        // crc start values are loaded at each start
                        s_next.crc16 = `FUH_CRC16_INIT;
                        s_next.rcrc = `FUH_CRC16_INIT;
                        s_next.rsp_hdr_ok = 1'b0;
                        s_next.pfull = 1'b0;
                    end
                end
                `FUH_REG_TARGET: s_next.tgt = wdata[7:0];
                `FUH_REG_LENGTH: s_next.len = wdata;
                `FUH_REG_LOCATION: s_next.loc = wdata;
                `FUH_REG_PCHK: s_next.pchk = wdata;
                `FUH_REG_STATUS: s_next.sts = s_reg.sts & ~wdata[2:0];
                `FUH_REG_MASK: s_next.mask = wdata[2:0];
                `FUH_REG_TXDATA: begin
                    // a full buffer refuses the write; software polls
                    if (s_reg.st == fuh_pkg::FUH_PAY && !s_reg.pfull) begin
                        s_next.pbyte = wdata[7:0];
                        s_next.pfull = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // events are merged into status last, so a set
        // wins over a clear in the same cycle
        s_next.sts = s_next.sts | ev;

        // -----------------------------------------------------
        // register reads
        // -----------------------------------------------------
        // read data is registered and stands one cycle only;
        // outside that cycle it drops back to zero
        if (rd) begin
            case (addr)
                `FUH_REG_CTRL: s_next.rdata = {16'h0, s_reg.cmd, 7'h0,
                    s_reg.busy};
                `FUH_REG_TARGET: s_next.rdata = {24'h0, s_reg.tgt};
                `FUH_REG_LENGTH: s_next.rdata = s_reg.len;
                `FUH_REG_LOCATION: s_next.rdata = s_reg.loc;
                `FUH_REG_PCHK: s_next.rdata = s_reg.pchk;
                `FUH_REG_STATUS: s_next.rdata = {29'h0, s_reg.sts};
                `FUH_REG_MASK: s_next.rdata = {29'h0, s_reg.mask};
                `FUH_REG_RESULT: s_next.rdata = {s_reg.rsp_tgt,
                    s_reg.rsp_cmd, s_reg.result, 7'h0, s_reg.rsp_hdr_ok};
                `FUH_REG_TXDATA: s_next.rdata = {31'h0, s_reg.pfull};
                `FUH_REG_INFO: s_next.rdata = s_reg.left;
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------
    // state register
    // ---------------------------------------------------------
    // one register holds every bit of state, reset to zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------
    // outputs: rdata and tx straight from flip-flops, irq gated from two
    // ---------------------------------------------------------
    // irq is a plain and-or of two registers, so it can only
    // move on a clock edge and never glitches between them
    assign rdata = s_reg.rdata;
    assign tx = s_reg.tx;
    assign irq = |(s_reg.sts & s_reg.mask);
endmodule : fuh_host

/* File: bench/fuh_host_properties.sv */
`timescale 1ns/1ns
module fuh_host_properties (
    input wire logic clock, // clock
    input wire logic rst_b, // reset
    input wire logic [3:0] addr, // index
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [31:0] rdata, // read data
    input wire logic irq, // interrupt
    input wire fuh_pkg::fuh_byte_s tx, // to device
    input wire logic tx_ready, // taken
    input wire fuh_pkg::fuh_byte_s rx // from device
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // a frame byte may not move or vanish before it is taken
    a_tx_held: assert property (tx.valid && !tx_ready |=> $stable(tx))
        else $error("tx byte moved early");
    a_tx_drop: assert property ($fell(tx.valid) |-> $past(tx_ready))
        else $error("tx byte dropped untaken");
    // read data stands one cycle, padding reads as zero
    a_rd_quiet: assert property (!$past(rd) |-> rdata == '0)
        else $error("read data outside a read");
    a_stat_bits: assert property (rd && addr == 4'h5 |=> !rdata[31:3])
        else $error("status wider than three bits");
    a_mask_bits: assert property (rd && addr == 4'h6 |=> !rdata[31:3])
        else $error("mask wider than three bits");
    a_result_pad: assert property (rd && addr == 4'h7 |=> !rdata[7:1])
        else $error("result padding not zero");
    // irq moves only after an answer byte or a software write
    a_irq_rise: assert property ($rose(irq) |-> $past(rx.valid || wr))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr))
        else $error("irq fell without a write");
    c_irq: cover property ($rose(irq));
    c_stall: cover property (tx.valid && !tx_ready);
    c_answer: cover property ($fell(rx.valid));
endmodule : fuh_host_properties
bind fuh_host fuh_host_properties i_props (.clock(clock), .rst_b(rst_b),
    .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .tx(tx),
    .tx_ready(tx_ready), .rx(rx));

/* File: bench/fuh_dev_model.sv */
`timescale 1ns/1ns
module fuh_dev_model #(
    parameter int MAX_LEN = 16 // free memory, kept small
) (
    input wire logic clock, // clock
    input wire logic rst_b, // reset
    input wire logic slow, // take every other cycle
    input wire logic bad_rsp, // spoil the answer check
    input wire fuh_pkg::fuh_byte_s tx, // frame from host
    output logic tx_ready, // byte taken
    output fuh_pkg::fuh_byte_s rx // answer to host
);
    localparam logic [31:0] P16 = 32'h10210000;
    logic [7:0] h [64];
    logic [7:0] q [$];
    logic [31:0] len, pc, hc;
    logic [7:0] st;
    int n;
    // msb first; the 16-bit check runs in the upper half
    function automatic logic [31:0] crc(logic [31:0] c, logic [7:0] b,
        logic [31:0] p);
        c ^= {b, 24'h000000};
        for (int i = 0; i < 8; i++) c = c[31] ? (c << 1) ^ p : c << 1;
        return c;
    endfunction : crc
    // header, payload, verdict; the idle answer line shows no stale byte
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_ready <= 1'b0;
            rx <= '0;
            n = 0;
        end else begin
            tx_ready <= slow ? !tx_ready : 1'b1;
            if (tx.valid && tx_ready) begin
                if (n < 64) h[n] = tx.data;
                else pc = crc(pc, tx.data, 32'h04C11DB7);
                n++;
                if (n == 64) pc = 32'hFFFFFFFF;
                len = {h[8], h[9], h[10], h[11]};
            end
            if (n >= 64 && n == 64 + len) begin
                hc = 32'h00000000;
                for (int i = 2; i < 62; i++) hc = crc(hc, h[i], P16);
                st = 8'h00;
                if (hc[31:16] !== {h[62], h[63]}) st = 8'hFB;
                else if (len > MAX_LEN) st = 8'hFA;
                else if (!h[7][0] && pc !== {h[58], h[59], h[60], h[61]})
                    st = 8'hFC;
                q = {8'hA1, 8'hEC, 8'h03, h[3], h[4], st};
                repeat (56) q.push_back(8'h00);
                hc = 32'h00000000;
                for (int i = 2; i < 62; i++) hc = crc(hc, q[i], P16);
                q.push_back(hc[31:24]);
                q.push_back(hc[23:16] ^ {7'h00, bad_rsp});
                n = 0;
            end
            if (q.size() > 0) rx <= '{q.pop_front(), 1'b1};
            else rx <= '{~rx.data, 1'b0};
        end
    end
endmodule : fuh_dev_model

/* File: bench/flash_update_frame_handler_bench.sv */
`timescale 1ns/1ns
module flash_update_frame_handler_bench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d, crc;
    logic wr = 1'b0, rd = 1'b0, slow = 1'b0, bad_rsp = 1'b0;
    logic irq, tx_ready;
    fuh_pkg::fuh_byte_s tx, rx;
    int miscompares = 0, n_compared = 0, ntx = 0, base;
    // per test: command, target, length, result, {bad, slow, skip, good}
    logic [7:0] cmds [5] = '{8'h0B, 8'h0C, 8'h0D, 8'h0C, 8'h0B};
    logic [7:0] tgts [5] = '{8'h00, 8'h01, 8'h02, 8'h01, 8'h00};
    logic [7:0] lens [5] = '{8'h05, 8'h08, 8'h03, 8'h14, 8'h04};
    // a skip request from software is never sent, so test 2 fails
    logic [7:0] res [5] = '{8'h00, 8'hFC, 8'hFC, 8'hFA, 8'h00};
    logic [3:0] fl [5] = '{4'h1, 4'h4, 4'h2, 4'h5, 4'h9};
    wire [31:0] head = {i_dev.h[0], i_dev.h[1], i_dev.h[2], i_dev.h[3]};
    fuh_host i_dut (.clock(clock), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .tx(tx), .tx_ready(tx_ready), .rx(rx));
    fuh_dev_model #(.MAX_LEN(16)) i_dev (.clock(clock), .rst_b(rst_b),
        .slow(slow), .bad_rsp(bad_rsp), .tx(tx), .tx_ready(tx_ready),
        .rx(rx));
    // clock, and a count of frame bytes taken
    always #5 clock = ~clock;
    always @(posedge clock) if (tx.valid && tx_ready) ntx++;
    // one bus cycle; what a read returns lands in d
    task automatic acc(input logic w, input logic [3:0] a,
        input logic [31:0] v);
        @(posedge clock);
        {addr, wdata, wr, rd} <= {a, v, w, !w};
        @(posedge clock);
        {wr, rd} <= 2'b00;
        #1 d = rdata;
    endtask : acc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("compared %0d, miscompared %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // watchdog far beyond five short frames
    initial begin
        #400000;
        miscompares++;
        end_sim();
    end
    // reset defaults, then each frame of the table
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        acc(1'b0, 4'h5, 32'h0);
        chk(d, 32'h0);
        acc(1'b0, 4'hF, 32'h0);
        chk(d | {31'h0, irq}, 32'h0);
        $display("test reset done");
        for (int t = 0; t < 5; t++) begin
            crc = 32'hFFFFFFFF;
            for (int i = 0; i < lens[t]; i++)
                crc = i_dev.crc(crc, 8'(i * 37 + t), 32'h04C11DB7);
            {bad_rsp, slow} <= fl[t][3:2];
            base = ntx;
            acc(1'b1, 4'h6, {31'h0, !fl[t][3]});
            acc(1'b1, 4'h1, {24'h0, tgts[t]});
            acc(1'b1, 4'h2, {24'h0, lens[t]});
            acc(1'b1, 4'h3, 32'h00001000);
            acc(1'b1, 4'h4, fl[t][0] ? crc : ~crc);
            acc(1'b1, 4'h0, {16'h0, cmds[t], 6'h0, fl[t][1], 1'b1});
            for (int i = 0; i < 300 && ntx < base + 64; i++) @(posedge clock);
            chk(head, {16'hA1EC, 8'h03, cmds[t]});
            for (int i = 0; i < lens[t]; i++) begin
                acc(1'b0, 4'h8, 32'h0);
                for (int k = 0; k < 50 && d[0] !== 1'b0; k++)
                    acc(1'b0, 4'h8, 32'h0);
                acc(1'b1, 4'h8, {24'h0, 8'(i * 37 + t)});
            end
            for (int k = 0; k < 400 && d[0] !== 1'b1; k++)
                acc(1'b0, 4'h5, 32'h0);
            chk(d, {29'h0, res[t] != 8'h00, fl[t][3], 1'b1});
            chk({31'h0, irq}, {31'h0, !fl[t][3]});
            acc(1'b0, 4'h9, 32'h0);
            chk(d, 32'h0);
            acc(1'b0, 4'h0, 32'h0);
            chk(d, {16'h0, cmds[t], 8'h00});
            if (!fl[t][3]) begin
                acc(1'b0, 4'h7, 32'h0);
                chk(d, {tgts[t], cmds[t], res[t], 8'h01});
            end
            acc(1'b1, 4'h6, 32'h1);
            chk({31'h0, irq}, 32'h1);
            acc(1'b1, 4'h5, 32'h7);
            chk({31'h0, irq}, 32'h0);
            $display("frame test %0d done", t);
        end
        end_sim();
    end
endmodule : flash_update_frame_handler_bench
